// file: rtl/host_mailbox_pkg.sv
package host_mailbox_pkg;

  // ----------------------------------------------------------------
  // local cpu bus addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_SYSTEM_CONTROL       = 16'hFFC4;
  localparam logic [15:0] ADDR_HOST_PORT_CONTROL    = 16'hFFF0;
  localparam logic [15:0] ADDR_HOST_INPUT_BYTE_ONE  = 16'hFFF4;
  localparam logic [15:0] ADDR_HOST_OUTPUT_BYTE_ONE = 16'hFFF5;
  localparam logic [15:0] ADDR_CHANNEL_STATUS_ONE   = 16'hFFF6;
  localparam logic [15:0] ADDR_HOST_INPUT_BYTE_TWO  = 16'hFFFC;
  localparam logic [15:0] ADDR_HOST_OUTPUT_BYTE_TWO = 16'hFFFD;
  localparam logic [15:0] ADDR_CHANNEL_STATUS_TWO   = 16'hFFFE;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SYSTEM_CONTROL_RESET    = 8'h09;
  localparam logic [7:0] HOST_PORT_CONTROL_RESET = 8'hF8;
  localparam logic [7:0] CHANNEL_STATUS_RESET    = 8'h00;
  localparam logic [7:0] HOST_PORT_CONTROL_ONES  = 8'hF8;
  localparam logic [7:0] UNMAPPED_READ_VALUE     = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SYSTEM_CONTROL_HOST_PORT_ENABLE_BIT  = 1;
  localparam int SYSTEM_CONTROL_RESET_INDICATOR_BIT   = 3;
  localparam int HOST_PORT_CONTROL_INPUT_FULL_IRQ_EN_CH2  = 2;
  localparam int HOST_PORT_CONTROL_INPUT_FULL_IRQ_EN_CH1  = 1;
  localparam int HOST_PORT_CONTROL_FAST_GATE_ENABLE_BIT   = 0;
  localparam int STATUS_CMD_DATA_BIT         = 3;
  localparam int STATUS_INPUT_FULL_BIT       = 1;
  localparam int STATUS_OUTPUT_FULL_BIT      = 0;
  localparam logic [7:0] STATUS_USER_MASK    = 8'hF4;

  // ----------------------------------------------------------------
  // host pin synchroniser
  // ----------------------------------------------------------------
  localparam int HOST_SYNC_STAGES = 2;
  localparam int HOST_CTRL_W      = 5;

endpackage

// file: rtl/host_pin_sync.sv
module host_pin_sync
  import host_mailbox_pkg::*;
#(
  parameter int WIDTH  = 8,
  parameter int STAGES = HOST_SYNC_STAGES
)(
  input  wire logic             sys_clk,   // system clock
  input  wire logic             rst_b,     // async reset, active low
  input  wire logic [WIDTH-1:0] raw_in,    // asynchronous pin levels
  output logic      [WIDTH-1:0] sync_out   // levels in sys_clk domain
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (STAGES < 2 || WIDTH < 1)
  begin : g_bad_param
    $error("host_pin_sync needs at least two stages");
  end

  logic [WIDTH-1:0] stage_reg [STAGES];

  // flop chain; first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < STAGES; i++)
      begin
        stage_reg[i] <= '1;
      end
    end
    else
    begin
      stage_reg[0] <= raw_in;
      for (int i = 1; i < STAGES; i++)
      begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  assign sync_out = stage_reg[STAGES-1];

endmodule

// file: rtl/dual_channel_host_mailbox.sv
module dual_channel_host_mailbox
  import host_mailbox_pkg::*;
#(
  parameter int DATA_W = 8
)(
  input  wire logic        sys_clk,            // 50 MHz system clock
  input  wire logic        rst_b,              // async reset, active low
  input  wire logic        hw_standby,         // hardware standby level
  input  wire logic [15:0] cpu_addr,           // local cpu address
  input  wire logic [7:0]  cpu_wdata,          // local cpu write data
  input  wire logic        cpu_rd_strobe,      // local read, active high
  input  wire logic        cpu_wr_strobe,      // local write, active high
  output logic      [7:0]  cpu_rdata,          // local read data
  input  wire logic        host_addr_select,   // host address select
  input  wire logic        chip_select_ch1_b,  // channel one select
  input  wire logic        chip_select_ch2_b,  // channel two select
  input  wire logic        host_read_strobe_b, // host read strobe
  input  wire logic        host_write_strobe_b,// host write strobe
  input  wire logic [7:0]  host_data_in,       // host data bus level
  output logic      [7:0]  host_data_out,      // host data bus drive
  output logic             host_data_oe,       // high while driving
  output logic             input_full_irq_ch1, // channel one interrupt
  output logic             input_full_irq_ch2, // channel two interrupt
  output logic             host_port_enable,   // slave mode active
  output logic             fast_gate_enable    // fast gate function on
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (DATA_W != 8)
  begin : g_bad_width
    $error("dual_channel_host_mailbox supports an 8-bit data path only");
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] system_control_reg;
  logic [2:0] host_port_control_reg;
  logic [7:0] host_input_byte_reg  [2];
  logic [7:0] host_output_byte_reg [2];
  logic [7:0] user_status_bits_reg [2];
  logic       cmd_data_reg         [2];
  logic       input_full_flag_reg  [2];
  logic       output_full_flag_reg [2];

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // assemble a status byte from its parts
  function automatic logic [7:0] status_byte(input logic [7:0] user,
                                             input logic       cmd,
                                             input logic       input_full_flag,
                                             input logic       output_full_flag);
    logic [7:0] v;
    v = user & STATUS_USER_MASK;
    v[STATUS_CMD_DATA_BIT]    = cmd;
    v[STATUS_INPUT_FULL_BIT]  = input_full_flag;
    v[STATUS_OUTPUT_FULL_BIT] = output_full_flag;
    return v;
  endfunction

  // pick the channel selected by the two chip selects, or none
  function automatic logic [1:0] host_channel(input logic cs1_b,
                                              input logic cs2_b);
    logic [1:0] v;
    v = 2'h0;
    if (!cs1_b && cs2_b)
    begin
      v = 2'h1;
    end
    else if (cs1_b && !cs2_b)
    begin
      v = 2'h2;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // host pin synchronisation
  // ----------------------------------------------------------------
  logic [HOST_CTRL_W+7:0] host_raw;
  logic [HOST_CTRL_W+7:0] host_sync;
  logic                   hs_ha0;
  logic                   hs_cs1_b;
  logic                   hs_cs2_b;
  logic                   hs_ior_b;
  logic                   hs_iow_b;
  logic [7:0]             hs_data;

  // data travels with the strobes so both see the same delay
  assign host_raw = {host_data_in, host_addr_select, chip_select_ch1_b,
                     chip_select_ch2_b, host_read_strobe_b,
                     host_write_strobe_b};

  host_pin_sync #(
    .WIDTH  (HOST_CTRL_W + 8),
    .STAGES (HOST_SYNC_STAGES)
  ) u_host_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .raw_in   (host_raw),
    .sync_out (host_sync)
  );

  assign hs_data  = host_sync[HOST_CTRL_W+7:HOST_CTRL_W];
  assign hs_ha0   = host_sync[4];
  assign hs_cs1_b = host_sync[3];
  assign hs_cs2_b = host_sync[2];
  assign hs_ior_b = host_sync[1];
  assign hs_iow_b = host_sync[0];

  // ----------------------------------------------------------------
  // host access decode
  // ----------------------------------------------------------------
  logic       port_on;
  logic [1:0] hs_chan;
  logic       host_wr_active;
  logic       host_rd_active;
  logic       iow_prev_reg;
  logic       ior_prev_reg;
  logic       iow_rise;
  logic       ior_rise;

  // both strobes low together is prohibited and does nothing
  assign port_on        = system_control_reg[SYSTEM_CONTROL_HOST_PORT_ENABLE_BIT];
  assign hs_chan        = host_channel(hs_cs1_b, hs_cs2_b);
  assign host_wr_active = port_on && hs_chan != 2'h0 && !hs_iow_b
                          && hs_ior_b;
  assign host_rd_active = port_on && hs_chan != 2'h0 && !hs_ior_b
                          && hs_iow_b;
  assign iow_rise       = !iow_prev_reg && hs_iow_b;
  assign ior_rise       = !ior_prev_reg && hs_ior_b;

  // strobe history for edge detection on synchronised levels
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      iow_prev_reg <= 1'b1;
      ior_prev_reg <= 1'b1;
    end
    else
    begin
      iow_prev_reg <= hs_iow_b;
      ior_prev_reg <= hs_ior_b;
    end
  end

  // ----------------------------------------------------------------
  // host write capture
  // ----------------------------------------------------------------
  logic       wr_pending_reg;
  logic       wr_chan_reg;
  logic       wr_ha0_reg;
  logic [7:0] wr_data_reg;
  logic       host_wr_commit;

  // last sampled values before the strobe rises are the ones kept
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_pending_reg <= 1'b0;
      wr_chan_reg    <= 1'b0;
      wr_ha0_reg     <= 1'b0;
      wr_data_reg    <= 8'h00;
    end
    else if (hw_standby || !port_on)
    begin
      wr_pending_reg <= 1'b0;
    end
    else if (host_wr_active)
    begin
      wr_pending_reg <= 1'b1;
      wr_chan_reg    <= hs_chan[1];
      wr_ha0_reg     <= hs_ha0;
      wr_data_reg    <= hs_data;
    end
    else if (iow_rise)
    begin
      wr_pending_reg <= 1'b0;
    end
  end

  assign host_wr_commit = wr_pending_reg && iow_rise;

  // ----------------------------------------------------------------
  // host read tracking
  // ----------------------------------------------------------------
  logic       rd_pending_reg;
  logic       rd_chan_reg;
  logic       host_rd_done;

  // only a read of the output byte, not of status, empties it
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_pending_reg <= 1'b0;
      rd_chan_reg    <= 1'b0;
    end
    else if (hw_standby || !port_on)
    begin
      rd_pending_reg <= 1'b0;
    end
    else if (host_rd_active)
    begin
      rd_pending_reg <= !hs_ha0;
      rd_chan_reg    <= hs_chan[1];
    end
    else if (ior_rise)
    begin
      rd_pending_reg <= 1'b0;
    end
  end

  assign host_rd_done = rd_pending_reg && ior_rise;

  // ----------------------------------------------------------------
  // local cpu access decode
  // ----------------------------------------------------------------
  logic cpu_rd_prev_reg;
  logic cpu_wr_prev_reg;
  logic cpu_rd_start;
  logic cpu_wr_start;

  // act once, on the cycle a strobe is first asserted
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cpu_rd_prev_reg <= 1'b0;
      cpu_wr_prev_reg <= 1'b0;
    end
    else
    begin
      cpu_rd_prev_reg <= cpu_rd_strobe;
      cpu_wr_prev_reg <= cpu_wr_strobe;
    end
  end

  assign cpu_rd_start = cpu_rd_strobe && !cpu_rd_prev_reg;
  assign cpu_wr_start = cpu_wr_strobe && !cpu_wr_prev_reg;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // reset indicator bit stays read only at its reset level
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      system_control_reg    <= SYSTEM_CONTROL_RESET;
      host_port_control_reg <= HOST_PORT_CONTROL_RESET[2:0];
    end
    else if (hw_standby)
    begin
      system_control_reg    <= SYSTEM_CONTROL_RESET;
      host_port_control_reg <= HOST_PORT_CONTROL_RESET[2:0];
    end
    else if (cpu_wr_start)
    begin
      if (cpu_addr == ADDR_SYSTEM_CONTROL)
      begin
        system_control_reg <= cpu_wdata;
        system_control_reg[SYSTEM_CONTROL_RESET_INDICATOR_BIT] <=
          system_control_reg[SYSTEM_CONTROL_RESET_INDICATOR_BIT];
      end
      if (cpu_addr == ADDR_HOST_PORT_CONTROL)
      begin
        host_port_control_reg <= cpu_wdata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // data bytes, deliberately without reset
  // ----------------------------------------------------------------
  // no reset keeps these as plain storage, contents start undefined
  always_ff @(posedge sys_clk)
  begin
    if (host_wr_commit)
    begin
      host_input_byte_reg[wr_chan_reg] <= wr_data_reg;
    end
    if (cpu_wr_start && cpu_addr == ADDR_HOST_OUTPUT_BYTE_ONE)
    begin
      host_output_byte_reg[0] <= cpu_wdata;
    end
    if (cpu_wr_start && cpu_addr == ADDR_HOST_OUTPUT_BYTE_TWO)
    begin
      host_output_byte_reg[1] <= cpu_wdata;
    end
  end

  // ----------------------------------------------------------------
  // status registers
  // ----------------------------------------------------------------
  logic [15:0] in_addr   [2];
  logic [15:0] out_addr  [2];
  logic [15:0] stat_addr [2];

  assign in_addr[0]   = ADDR_HOST_INPUT_BYTE_ONE;
  assign in_addr[1]   = ADDR_HOST_INPUT_BYTE_TWO;
  assign out_addr[0]  = ADDR_HOST_OUTPUT_BYTE_ONE;
  assign out_addr[1]  = ADDR_HOST_OUTPUT_BYTE_TWO;
  assign stat_addr[0] = ADDR_CHANNEL_STATUS_ONE;
  assign stat_addr[1] = ADDR_CHANNEL_STATUS_TWO;

  // a set in the same cycle as a clear wins, so no event is lost
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int c = 0; c < 2; c++)
      begin
        user_status_bits_reg[c] <= CHANNEL_STATUS_RESET;
        cmd_data_reg[c]         <= 1'b0;
        input_full_flag_reg[c]  <= 1'b0;
        output_full_flag_reg[c] <= 1'b0;
      end
    end
    else if (hw_standby)
    begin
      for (int c = 0; c < 2; c++)
      begin
        user_status_bits_reg[c] <= CHANNEL_STATUS_RESET;
        cmd_data_reg[c]         <= 1'b0;
        input_full_flag_reg[c]  <= 1'b0;
        output_full_flag_reg[c] <= 1'b0;
      end
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (cpu_wr_start && cpu_addr == stat_addr[c])
        begin
          user_status_bits_reg[c] <= cpu_wdata & STATUS_USER_MASK;
        end
        if (host_wr_commit && int'(wr_chan_reg) == c)
        begin
          cmd_data_reg[c]        <= wr_ha0_reg;
          input_full_flag_reg[c] <= 1'b1;
        end
        else if (cpu_rd_start && cpu_addr == in_addr[c])
        begin
          input_full_flag_reg[c] <= 1'b0;
        end
        if (cpu_wr_start && cpu_addr == out_addr[c])
        begin
          output_full_flag_reg[c] <= 1'b1;
        end
        else if (host_rd_done && int'(rd_chan_reg) == c)
        begin
          output_full_flag_reg[c] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // local cpu read data
  // ----------------------------------------------------------------
  logic [7:0] cpu_read_value;

  // unmapped addresses read as zero
  always_comb
  begin
    cpu_read_value = UNMAPPED_READ_VALUE;
    case (cpu_addr)
      ADDR_SYSTEM_CONTROL:       cpu_read_value = system_control_reg;
      ADDR_HOST_PORT_CONTROL:    cpu_read_value = HOST_PORT_CONTROL_ONES
                                   | {5'h00, host_port_control_reg};
      ADDR_HOST_INPUT_BYTE_ONE:  cpu_read_value = host_input_byte_reg[0];
      ADDR_HOST_OUTPUT_BYTE_ONE: cpu_read_value = host_output_byte_reg[0];
      ADDR_CHANNEL_STATUS_ONE:   cpu_read_value = status_byte(
        user_status_bits_reg[0], cmd_data_reg[0],
        input_full_flag_reg[0], output_full_flag_reg[0]);
      ADDR_HOST_INPUT_BYTE_TWO:  cpu_read_value = host_input_byte_reg[1];
      ADDR_HOST_OUTPUT_BYTE_TWO: cpu_read_value = host_output_byte_reg[1];
      ADDR_CHANNEL_STATUS_TWO:   cpu_read_value = status_byte(
        user_status_bits_reg[1], cmd_data_reg[1],
        input_full_flag_reg[1], output_full_flag_reg[1]);
      default:                   cpu_read_value = UNMAPPED_READ_VALUE;
    endcase
  end

  // read data is held until the next read starts
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cpu_rdata <= UNMAPPED_READ_VALUE;
    end
    else if (cpu_rd_start)
    begin
      cpu_rdata <= cpu_read_value;
    end
  end

  // ----------------------------------------------------------------
  // host data bus drive
  // ----------------------------------------------------------------
  logic       host_sel_ch;
  logic [7:0] host_read_value;

  // address select low picks the output byte, high the status
  assign host_sel_ch     = hs_chan[1];
  assign host_read_value = hs_ha0
    ? status_byte(user_status_bits_reg[host_sel_ch],
                  cmd_data_reg[host_sel_ch],
                  input_full_flag_reg[host_sel_ch],
                  output_full_flag_reg[host_sel_ch])
    : host_output_byte_reg[host_sel_ch];

  // bus released on the clock after the synchronised read strobe rises
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      host_data_out <= 8'h00;
      host_data_oe  <= 1'b0;
    end
    else if (hw_standby)
    begin
      host_data_out <= 8'h00;
      host_data_oe  <= 1'b0;
    end
    else
    begin
      host_data_oe  <= host_rd_active;
      host_data_out <= host_rd_active ? host_read_value : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // interrupt and control outputs
  // ----------------------------------------------------------------
  // level requests: they follow the flag until the cpu reads
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      input_full_irq_ch1 <= 1'b0;
      input_full_irq_ch2 <= 1'b0;
      host_port_enable   <= 1'b0;
      fast_gate_enable   <= 1'b0;
    end
    else
    begin
      input_full_irq_ch1 <= input_full_flag_reg[0]
        && host_port_control_reg[HOST_PORT_CONTROL_INPUT_FULL_IRQ_EN_CH1]
        && !hw_standby;
      input_full_irq_ch2 <= input_full_flag_reg[1]
        && host_port_control_reg[HOST_PORT_CONTROL_INPUT_FULL_IRQ_EN_CH2]
        && !hw_standby;
      host_port_enable   <= port_on && !hw_standby;
      fast_gate_enable   <= host_port_control_reg[HOST_PORT_CONTROL_FAST_GATE_ENABLE_BIT]
        && !hw_standby;
    end
  end

endmodule

// file: test/host_mailbox_chk.sv
module host_mailbox_chk
  import host_mailbox_pkg::*;
(
  input wire logic        sys_clk,            // clock
  input wire logic        rst_b,              // reset, low
  input wire logic        hw_standby,         // standby
  input wire logic [15:0] cpu_addr,           // cpu address
  input wire logic [7:0]  cpu_wdata,          // cpu data
  input wire logic        cpu_rd_strobe,      // cpu read
  input wire logic        cpu_wr_strobe,      // cpu write
  input wire logic        host_read_strobe_b, // host read
  input wire logic        host_data_oe,       // bus drive
  input wire logic        input_full_irq_ch1, // irq one
  input wire logic        input_full_irq_ch2, // irq two
  input wire logic        host_port_enable,   // slave mode
  input wire logic        fast_gate_enable    // gate on
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic quiet;

  // all control outputs low together
  assign quiet = !(host_port_enable || fast_gate_enable
                   || input_full_irq_ch1 || input_full_irq_ch2);

  a_reset_quiet: assert property ($rose(rst_b) |-> quiet)
    else $error("outputs set after reset");
  a_standby_quiet: assert property (hw_standby [*4] |-> quiet)
    else $error("outputs set in standby");
  a_enable_write:
    assert property ($rose(cpu_wr_strobe) && cpu_addr == ADDR_SYSTEM_CONTROL
      |-> ##2 host_port_enable == $past(cpu_wdata[1], 2))
    else $error("slave mode misses write");
  a_gate_write:
    assert property ($rose(cpu_wr_strobe) && cpu_addr == ADDR_HOST_PORT_CONTROL
      |-> ##2 fast_gate_enable == $past(cpu_wdata[0], 2))
    else $error("gate enable misses write");
  a_irq_one_mask:
    assert property ($rose(cpu_wr_strobe) && cpu_addr == ADDR_HOST_PORT_CONTROL
      && !cpu_wdata[1] |-> ##2 !input_full_irq_ch1)
    else $error("masked irq one seen");
  a_irq_one_clear:
    assert property ($rose(cpu_rd_strobe)
      && cpu_addr == ADDR_HOST_INPUT_BYTE_ONE |-> ##2 !input_full_irq_ch1)
    else $error("irq one after read");
  a_irq_two_clear:
    assert property ($rose(cpu_rd_strobe)
      && cpu_addr == ADDR_HOST_INPUT_BYTE_TWO |-> ##2 !input_full_irq_ch2)
    else $error("irq two after read");
  a_drive_cause:
    assert property ($rose(host_data_oe) |-> !host_read_strobe_b
      && host_port_enable)
    else $error("bus driven without read");
  c_read: cover property ($rose(host_data_oe));
  c_irq_one: cover property ($rose(input_full_irq_ch1));
  c_irq_two: cover property ($rose(input_full_irq_ch2));
endmodule

bind dual_channel_host_mailbox host_mailbox_chk chk (.*);

// file: test/host_model.sv
module host_model
(
  input  wire logic       sys_clk,                    // pacing
  input  wire logic [7:0] bus,                        // bus level
  output logic            host_addr_select = 1'b0,    // cmd or data
  output logic            chip_select_ch1_b = 1'b1,   // select one
  output logic            chip_select_ch2_b = 1'b1,   // select two
  output logic            host_read_strobe_b = 1'b1,  // read
  output logic            host_write_strobe_b = 1'b1, // write
  output logic      [7:0] host_drive = 8'h00          // our drive
);
  timeunit 1ns;
  timeprecision 1ns;

  // strobe low 6, high 6: covers the two-flop delay both ways
  // on a read we drive the inverse, so a silent slave cannot pass
  task automatic xfer(input bit wr, input bit ch, input bit a,
                      input logic [7:0] d, output logic [7:0] q);
    @(negedge sys_clk);
    host_addr_select = a;
    chip_select_ch1_b = ch;
    chip_select_ch2_b = !ch;
    host_drive = wr ? d : ~d;
    @(negedge sys_clk);
    host_read_strobe_b = wr;
    host_write_strobe_b = !wr;
    repeat (6) @(negedge sys_clk);
    q = bus;
    host_read_strobe_b = 1'b1;
    host_write_strobe_b = 1'b1;
    repeat (6) @(negedge sys_clk);
    chip_select_ch1_b = 1'b1;
    chip_select_ch2_b = 1'b1;
    // released bus must not keep the old byte
    host_drive = ~d;
  endtask
endmodule

// file: test/tb.sv
module tb
  import host_mailbox_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam bit RD = 1'b0;
  localparam bit WR = 1'b1;
  localparam bit ONE = 1'b0;
  localparam bit TWO = 1'b1;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        hw_standby = 1'b0;
  logic        cpu_rd_strobe = 1'b0;
  logic        cpu_wr_strobe = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0]  cpu_wdata = 8'h00;
  logic [7:0]  cpu_rdata, host_data_out, host_drive, v;
  logic        host_addr_select, chip_select_ch1_b, chip_select_ch2_b;
  logic        host_read_strobe_b, host_write_strobe_b, host_data_oe;
  logic        input_full_irq_ch1, input_full_irq_ch2;
  logic        host_port_enable, fast_gate_enable;
  int          mismatches = 0;
  int          comparisons = 0;
  wire logic [7:0] bus = host_data_oe ? host_data_out : host_drive;
  wire logic [7:0] outs = {4'h0, input_full_irq_ch2, input_full_irq_ch1,
                           host_port_enable, fast_gate_enable};

  dual_channel_host_mailbox dut (.*, .host_data_in(bus));
  host_model host (.*);

  always #10 sys_clk = ~sys_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // local access; on a read, d is the expected byte
  task automatic cpu(input bit wr, input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr_strobe = wr;
    cpu_rd_strobe = !wr;
    @(negedge sys_clk);
    cpu_wr_strobe = 1'b0;
    cpu_rd_strobe = 1'b0;
    @(negedge sys_clk);
    if (!wr)
      chk(cpu_rdata, d, "cpu_rdata");
  endtask

  task automatic hcyc(input bit wr, input bit ch, input bit a,
                      input logic [7:0] d);
    host.xfer(wr, ch, a, d, v);
    if (!wr)
      chk(v, d, "host bus");
  endtask

  task automatic test_reset;
    cpu(RD, ADDR_SYSTEM_CONTROL, 8'h09);
    cpu(RD, ADDR_HOST_PORT_CONTROL, 8'hF8);
    cpu(RD, ADDR_CHANNEL_STATUS_ONE, 8'h00);
    cpu(RD, ADDR_CHANNEL_STATUS_TWO, 8'h00);
    cpu(RD, 16'hFFF1, 8'h00);
    chk(outs, 8'h00, "outs");
    $display("reset values done");
  endtask

  // bit 3 of the write must be dropped by the fixed ones
  task automatic test_control;
    cpu(WR, ADDR_HOST_PORT_CONTROL, 8'h09);
    cpu(RD, ADDR_HOST_PORT_CONTROL, 8'hF9);
    chk(outs, 8'h01, "outs");
    hcyc(WR, ONE, 1'b1, 8'h11);
    cpu(RD, ADDR_CHANNEL_STATUS_ONE, 8'h00);
    $display("control done");
  endtask

  task automatic test_one;
    cpu(WR, ADDR_SYSTEM_CONTROL, 8'h02);
    cpu(RD, ADDR_SYSTEM_CONTROL, 8'h0A);
    cpu(WR, ADDR_HOST_PORT_CONTROL, 8'h02);
    hcyc(WR, ONE, 1'b1, 8'hA5);
    cpu(RD, ADDR_CHANNEL_STATUS_ONE, 8'h0A);
    chk(outs, 8'h06, "outs");
    cpu(RD, ADDR_HOST_INPUT_BYTE_ONE, 8'hA5);
    cpu(RD, ADDR_CHANNEL_STATUS_ONE, 8'h08);
    hcyc(WR, ONE, 1'b0, 8'h5A);
    cpu(RD, ADDR_CHANNEL_STATUS_ONE, 8'h02);
    cpu(RD, ADDR_HOST_INPUT_BYTE_ONE, 8'h5A);
    chk(outs, 8'h02, "outs");
    $display("channel one done");
  endtask

  task automatic test_two;
    cpu(WR, ADDR_HOST_PORT_CONTROL, 8'h04);
    hcyc(WR, TWO, 1'b1, 8'h3C);
    cpu(RD, ADDR_CHANNEL_STATUS_TWO, 8'h0A);
    chk(outs, 8'h0A, "outs");
    cpu(RD, ADDR_HOST_INPUT_BYTE_TWO, 8'h3C);
    cpu(RD, ADDR_CHANNEL_STATUS_TWO, 8'h08);
    $display("channel two done");
  endtask

  task automatic test_output;
    cpu(WR, ADDR_HOST_OUTPUT_BYTE_ONE, 8'hC3);
    cpu(WR, ADDR_HOST_OUTPUT_BYTE_TWO, 8'h96);
    cpu(RD, ADDR_CHANNEL_STATUS_ONE, 8'h01);
    hcyc(RD, ONE, 1'b0, 8'hC3);
    cpu(RD, ADDR_CHANNEL_STATUS_ONE, 8'h00);
    hcyc(RD, TWO, 1'b1, 8'h09);
    hcyc(RD, TWO, 1'b0, 8'h96);
    cpu(RD, ADDR_CHANNEL_STATUS_TWO, 8'h08);
    $display("output done");
  endtask

  task automatic test_user;
    cpu(WR, ADDR_CHANNEL_STATUS_TWO, 8'hFF);
    cpu(RD, ADDR_CHANNEL_STATUS_TWO, 8'hFC);
    hcyc(RD, TWO, 1'b1, 8'hFC);
    cpu(WR, ADDR_CHANNEL_STATUS_TWO, 8'h00);
    cpu(RD, ADDR_CHANNEL_STATUS_TWO, 8'h08);
    $display("user bits done");
  endtask

  task automatic test_standby;
    cpu(WR, ADDR_HOST_PORT_CONTROL, 8'h07);
    hw_standby = 1'b1;
    repeat (5) @(negedge sys_clk);
    chk(outs, 8'h00, "outs");
    hw_standby = 1'b0;
    cpu(RD, ADDR_SYSTEM_CONTROL, 8'h09);
    cpu(RD, ADDR_HOST_PORT_CONTROL, 8'hF8);
    cpu(RD, ADDR_CHANNEL_STATUS_TWO, 8'h00);
    $display("standby done");
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(negedge sys_clk);
    rst_b = 1'b1;
    test_reset();
    test_control();
    test_one();
    test_two();
    test_output();
    test_user();
    test_standby();
    complete_run();
  end

  // tests need under 10 us; five times that means a hang
  initial
  begin
    #50us;
    mismatches++;
    complete_run();
  end
endmodule
